// ===== core/twm_timer.sv
`timescale 1ns/1ps
`include "twm_defs.svh"

module twm_timer
  import twm_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // avalon-mm slave
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [4:0]    avs_address,
  input  wire logic [31:0]   avs_writedata,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  // compare output pins
  output logic [1:0]         compare_out,
  output logic [1:0]         pin_out,
  output logic [1:0]         pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////
  // state and decode

  twm_state_t   s_reg;          // registered state
  twm_state_t   s_next;         // next state
  twm_bus_req_t req;            // bundled bus request
  logic         tick;           // timer clock enable
  logic         is_pc;          // dual-slope mode
  logic         is_fast;        // single-slope mode
  logic         is_clear;       // clear-on-match mode
  logic         is_pwm;         // either pwm mode
  logic [7:0]   top;            // current top value
  logic         at_top;         // counter equals top
  logic         at_bottom;      // counter at bottom
  logic         high_bit;       // waveform_mode_high_bit
  logic [1:0]   match;          // unblocked compare matches
  logic [1:0]   out_next;       // per-channel output state
  logic [31:0]  rd_mux;         // read data selection
  logic         wr_done;        // write completes this edge
  logic [7:0]   cnt_next;       // counter next value
  logic         dir_next;       // direction next value
  logic         ovf_set;        // overflow event
  logic         load_buf;       // buffered compare transfer

  assign req.read      = avs_read;
  assign req.write     = avs_write;
  assign req.address   = avs_address;
  assign req.writedata = avs_writedata;

  // outputs come straight from state flops
  assign avs_readdata    = s_reg.rdata;
  assign avs_waitrequest = s_reg.waitreq;
  assign compare_out     = s_reg.cmp_out;
  assign pin_out         = s_reg.pin_out;
  assign pin_oe_n        = s_reg.pin_oe_n;

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  // codes 4 and 6 fall back to plain up counting
  always_comb
  begin
    high_bit = s_reg.mode[`TWM_MODE_HIGH_BIT];
    is_pc    = (s_reg.mode == `TWM_MODE_PC_FF) ||
               (s_reg.mode == `TWM_MODE_PC_A);
    is_fast  = (s_reg.mode == `TWM_MODE_FAST_FF) ||
               (s_reg.mode == `TWM_MODE_FAST_A);
    is_clear = (s_reg.mode == `TWM_MODE_CLEAR);
    is_pwm   = is_pc || is_fast;
    // compare A becomes top in modes 5 and 7
    if (is_pwm && high_bit)
    begin
      top = s_reg.cmp_act[0];
    end
    else if (is_clear)
    begin
      top = s_reg.cmp_act[0];
    end
    else
    begin
      top = `TWM_MAX;
    end
    at_top    = (s_reg.count == top);
    at_bottom = (s_reg.count == `TWM_BOTTOM);
  end

  ////////////////////////////////////////////////////////////////////////
  // timer tick: software divider stands in for the prescaler

  assign tick = (s_reg.div_cnt == s_reg.div);

  ////////////////////////////////////////////////////////////////////////
  // counter sequencing

  always_comb
  begin
    cnt_next = s_reg.count;
    dir_next = s_reg.dir_down;
    ovf_set  = 1'b0;
    load_buf = 1'b0;
    if (is_clear)
    begin
      cnt_next = match[0] ? `TWM_BOTTOM : s_reg.count + 8'h01;
      ovf_set  = (s_reg.count == `TWM_MAX) && !match[0];
      dir_next = 1'b0;
    end
    else if (is_fast)
    begin
      cnt_next = at_top ? `TWM_BOTTOM : s_reg.count + 8'h01;
      ovf_set  = at_top;
      load_buf = at_top;
      dir_next = 1'b0;
    end
    else if (is_pc)
    begin
      ovf_set = at_bottom;
      if (top == `TWM_BOTTOM)
      begin
        // degenerate top: counter rests at bottom
        cnt_next = `TWM_BOTTOM;
        load_buf = 1'b1;
      end
      else if (!s_reg.dir_down)
      begin
        if (s_reg.count >= top)
        begin
          cnt_next = top - 8'h01;
          dir_next = 1'b1;
          load_buf = 1'b1;
        end
        else
        begin
          cnt_next = s_reg.count + 8'h01;
        end
      end
      else if (at_bottom)
      begin
        // turn upward again at bottom
        cnt_next = 8'h01;
        dir_next = 1'b0;
      end
      else
      begin
        cnt_next = s_reg.count - 8'h01;
      end
    end
    else
    begin
      // plain up counting wraps by itself
      cnt_next = s_reg.count + 8'h01;
      ovf_set  = (s_reg.count == `TWM_MAX);
      dir_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel compare and waveform logic

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      logic [1:0] act;          // output_action_sel of channel
      logic       tog_ok;       // toggle allowed in this mode
      logic       up_res;       // up-count match result
      logic       dn_res;       // down-count match result
      logic       ocr_top;      // compare sits at top
      logic       ocr_bot;      // compare sits at bottom

      assign act     = (gi == 0) ? s_reg.act_a : s_reg.act_b;
      assign ocr_top = (s_reg.cmp_act[gi] == top);
      assign ocr_bot = (s_reg.cmp_act[gi] == `TWM_BOTTOM);
      // a write to the counter blocks one tick of matches
      assign match[gi] = (s_reg.count == s_reg.cmp_act[gi]) &&
                         !s_reg.block;
      // in pwm modes toggle only on A with high bit
      assign tog_ok  = !is_pwm || ((gi == 0) && high_bit);
      assign up_res  = act[0];
      assign dn_res  = !act[0];

      always_comb
      begin
        out_next[gi] = s_reg.cmp_out[gi];
        if (!is_pwm)
        begin
          if (match[gi])
          begin
            unique case (act)
              2'd0: out_next[gi] = s_reg.cmp_out[gi];
              2'd1: out_next[gi] = !s_reg.cmp_out[gi];
              2'd2: out_next[gi] = 1'b0;
              2'd3: out_next[gi] = 1'b1;
            endcase
          end
        end
        else if (act[1] && is_fast)
        begin
          // set at bottom, clear on match
          // match at top ignored, bottom rules
          if (at_top)
          begin
            out_next[gi] = dn_res;
          end
          else if (match[gi] && !ocr_top)
          begin
            out_next[gi] = up_res;
          end
        end
        else if (act[1] && is_pc)
        begin
          if (at_top && !s_reg.dir_down)
          begin
            out_next[gi] = ocr_top ? dn_res : up_res;
          end
          else if (at_bottom)
          begin
            out_next[gi] = ocr_bot ? up_res : dn_res;
          end
          // clear going up, set going down
          else if (match[gi])
          begin
            out_next[gi] = s_reg.dir_down ? dn_res : up_res;
          end
        end
        // low bit toggles with high bit
        else if ((act == 2'd1) && tog_ok && match[gi])
        begin
          out_next[gi] = !s_reg.cmp_out[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // register read mux

  always_comb
  begin
    rd_mux = `TWM_RST_WORD;
    unique case (req.address)
      `TWM_OFS_CTRL:
      begin
        rd_mux[`TWM_CTRL_MODE_LSB +: 3] = s_reg.mode;
        rd_mux[`TWM_CTRL_ACTB_LSB +: 2] = s_reg.act_b;
        rd_mux[`TWM_CTRL_ACTA_LSB +: 2] = s_reg.act_a;
      end
      `TWM_OFS_COUNT: rd_mux[7:0] = s_reg.count;
      // software sees the buffer, which is live outside pwm
      `TWM_OFS_CMP_A: rd_mux[7:0] = s_reg.cmp_buf[0];
      `TWM_OFS_CMP_B: rd_mux[7:0] = s_reg.cmp_buf[1];
      `TWM_OFS_FLAGS:
      begin
        rd_mux[`TWM_FLG_OVF]  = s_reg.ovf_flag;
        rd_mux[`TWM_FLG_CMPA] = s_reg.cmp_flag[0];
        rd_mux[`TWM_FLG_CMPB] = s_reg.cmp_flag[1];
      end
      `TWM_OFS_PINS:
      begin
        rd_mux[`TWM_PIN_DIR_LSB +: 2]  = s_reg.pin_dir;
        rd_mux[`TWM_PIN_PORT_LSB +: 2] = s_reg.port_val;
      end
      `TWM_OFS_DIV: rd_mux[7:0] = s_reg.div;
      // unmapped offsets read as zero
      default: rd_mux = `TWM_RST_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    s_next  = s_reg;
    wr_done = req.write && !s_reg.waitreq;

    // bus handshake: one wait cycle, then a single ready cycle
    if ((req.read || req.write) && s_reg.waitreq)
    begin
      s_next.waitreq = 1'b0;
      s_next.rdata   = req.read ? rd_mux : s_reg.rdata;
    end
    else
    begin
      s_next.waitreq = 1'b1;
    end

    // divider for the timer tick
    s_next.div_cnt = tick ? `TWM_RST_BYTE : s_reg.div_cnt + 8'h01;

    // timer advance on each tick
    if (tick)
    begin
      s_next.count    = cnt_next;
      s_next.dir_down = dir_next;
      s_next.cmp_out  = out_next;
      s_next.block    = 1'b0;
      // flag follows match by one tick
      // A flag on top in clear mode
      s_next.match_pend = match;
      s_next.cmp_flag   = s_reg.cmp_flag | s_reg.match_pend;
      s_next.ovf_flag   = s_reg.ovf_flag | ovf_set;
      if (is_pwm && load_buf)
      begin
        s_next.cmp_act = s_reg.cmp_buf;
      end
    end

    // register writes; flag sets win over clears
    if (wr_done)
    begin
      unique case (req.address)
        `TWM_OFS_CTRL:
        begin
          s_next.mode  = req.writedata[`TWM_CTRL_MODE_LSB +: 3];
          s_next.act_b = req.writedata[`TWM_CTRL_ACTB_LSB +: 2];
          s_next.act_a = req.writedata[`TWM_CTRL_ACTA_LSB +: 2];
        end
        `TWM_OFS_COUNT:
        begin
          // write beats the tick and blocks the next match
          s_next.count      = req.writedata[7:0];
          s_next.block      = 1'b1;
          s_next.match_pend = 2'b00;
        end
        `TWM_OFS_CMP_A:
        begin
          s_next.cmp_buf[0] = req.writedata[7:0];
          if (!is_pwm)
          begin
            s_next.cmp_act[0] = req.writedata[7:0];
          end
        end
        `TWM_OFS_CMP_B:
        begin
          s_next.cmp_buf[1] = req.writedata[7:0];
          if (!is_pwm)
          begin
            s_next.cmp_act[1] = req.writedata[7:0];
          end
        end
        `TWM_OFS_FLAGS:
        begin
          s_next.ovf_flag = (s_reg.ovf_flag &
                             !req.writedata[`TWM_FLG_OVF]) |
                            (tick & ovf_set);
          s_next.cmp_flag[0] = (s_reg.cmp_flag[0] &
                                !req.writedata[`TWM_FLG_CMPA]) |
                               (tick & s_reg.match_pend[0]);
          s_next.cmp_flag[1] = (s_reg.cmp_flag[1] &
                                !req.writedata[`TWM_FLG_CMPB]) |
                               (tick & s_reg.match_pend[1]);
        end
        `TWM_OFS_PINS:
        begin
          s_next.pin_dir  = req.writedata[`TWM_PIN_DIR_LSB +: 2];
          s_next.port_val = req.writedata[`TWM_PIN_PORT_LSB +: 2];
        end
        `TWM_OFS_DIV:
        begin
          s_next.div     = req.writedata[7:0];
          s_next.div_cnt = `TWM_RST_BYTE;
        end
        // unmapped writes are dropped
        default: s_next.div = s_next.div;
      endcase
    end

    // pin driven only when direction out
    // the override applies only while an action is selected
    s_next.pin_out[0]  = (s_next.act_a != 2'd0) ? s_next.cmp_out[0]
                                                : s_next.port_val[0];
    s_next.pin_out[1]  = (s_next.act_b != 2'd0) ? s_next.cmp_out[1]
                                                : s_next.port_val[1];
    s_next.pin_oe_n    = ~s_next.pin_dir;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  // all state resets to constants; outputs idle with pins released
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg          <= '0;
      s_reg.waitreq  <= 1'b1;
      s_reg.pin_oe_n <= 2'b11;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

endmodule : twm_timer

// ===== inc/twm_defs.svh
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH

// register byte offsets
`define TWM_OFS_CTRL      5'h00
`define TWM_OFS_COUNT     5'h04
`define TWM_OFS_CMP_A     5'h08
`define TWM_OFS_CMP_B     5'h0C
`define TWM_OFS_FLAGS     5'h10
`define TWM_OFS_PINS      5'h14
`define TWM_OFS_DIV       5'h18

// control field positions
`define TWM_CTRL_MODE_LSB 0
`define TWM_CTRL_ACTB_LSB 4
`define TWM_CTRL_ACTA_LSB 6
`define TWM_MODE_HIGH_BIT 2

// flag bit positions
`define TWM_FLG_OVF       0
`define TWM_FLG_CMPA      1
`define TWM_FLG_CMPB      2

// pin register bit positions
`define TWM_PIN_DIR_LSB   0
`define TWM_PIN_PORT_LSB  2

// waveform mode codes
`define TWM_MODE_NORMAL   3'h0
`define TWM_MODE_PC_FF    3'h1
`define TWM_MODE_CLEAR    3'h2
`define TWM_MODE_FAST_FF  3'h3
`define TWM_MODE_PC_A     3'h5
`define TWM_MODE_FAST_A   3'h7

// counter extremes and reset values
`define TWM_BOTTOM        8'h00
`define TWM_MAX           8'hFF
`define TWM_RST_BYTE      8'h00
`define TWM_RST_WORD      32'h0000_0000

`endif

// ===== inc/twm_pkg.sv
package twm_pkg;

  // bus request carried as one group
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
  } twm_bus_req_t;

  // whole state of the timer block
  typedef struct packed {
    logic [2:0]       mode;
    logic [1:0]       act_a;
    logic [1:0]       act_b;
    logic [7:0]       count;
    logic             dir_down;
    logic [1:0][7:0]  cmp_buf;
    logic [1:0][7:0]  cmp_act;
    logic [1:0]       cmp_out;
    logic [1:0]       match_pend;
    logic             ovf_flag;
    logic [1:0]       cmp_flag;
    logic             block;
    logic [1:0]       pin_dir;
    logic [1:0]       port_val;
    logic [7:0]       div;
    logic [7:0]       div_cnt;
    logic             waitreq;
    logic [31:0]      rdata;
    logic [1:0]       pin_out;
    logic [1:0]       pin_oe_n;
  } twm_state_t;

endpackage : twm_pkg

// ===== testbench/twm_pin_load.sv
`timescale 1ns/1ps
module twm_pin_load
(
  // pad drive from the timer
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe_n,
  // level seen on the board
  output logic [1:0]      pin_level
);
  assign pin_level = pin_out & ~pin_oe_n;
endmodule : twm_pin_load

// ===== testbench/twm_timer_monitor.sv
`timescale 1ns/1ps
`include "twm_defs.svh"
module twm_timer_monitor
  import twm_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [4:0]  avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // compare outputs and pads
  input wire logic [1:0]  compare_out,
  input wire logic [1:0]  pin_out,
  input wire logic [1:0]  pin_oe_n
);
  // long enough for a buffered compare to load and the output to settle
  localparam int SETTLE = 900;
  logic       done_wr; // a write completes here
  logic       quiet_a; // action a cannot move output a
  logic       quiet_b; // action b cannot move output b
  logic [7:0] ctrl_sh; // last control byte written
  logic [7:0] cmpa_sh; // last compare a byte written
  logic [9:0] age;     // cycles since the last write
  logic [1:0] qa;      // cycles channel a stayed quiet
  logic [1:0] qb;      // cycles channel b stayed quiet

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // pwm modes are exactly the odd mode codes
  assign done_wr = avs_write && !avs_waitrequest;
  assign quiet_a = ctrl_sh[7:6] == 2'h0
                   || (ctrl_sh[7:6] == 2'h1 && ctrl_sh[0] && !ctrl_sh[2]);
  assign quiet_b = ctrl_sh[5:4] == 2'h0
                   || (ctrl_sh[5:4] == 2'h1 && ctrl_sh[0]);

  // shadow settings; counters wait out the registered output lag
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_sh <= 8'h00;
      cmpa_sh <= 8'h00;
      age     <= 10'd0;
      qa      <= 2'd0;
      qb      <= 2'd0;
    end
    else
    begin
      if (done_wr && avs_address == `TWM_OFS_CTRL)
        ctrl_sh <= avs_writedata[7:0];
      if (done_wr && avs_address == `TWM_OFS_CMP_A)
        cmpa_sh <= avs_writedata[7:0];
      age <= done_wr ? 10'd0 : (age == 10'(SETTLE) ? age : age + 10'd1);
      qa  <= (done_wr || !quiet_a) ? 2'd0 : (qa == 2'd3 ? qa : qa + 2'd1);
      qb  <= (done_wr || !quiet_b) ? 2'd0 : (qb == 2'd3 ? qb : qb + 2'd1);
    end
  end

  wait_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait request low for more than one cycle");
  wait_idle_a: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("wait request dropped with no request");
  hold_out_a: assert property (
    qa == 2'd3 |-> $stable(compare_out[0]))
    else $error("output a moved under a no-change action");
  hold_out_b: assert property (
    qb == 2'd3 |-> $stable(compare_out[1]))
    else $error("output b moved under a no-change action");
  extreme_hold_a: assert property (
    age == SETTLE && ctrl_sh[7:6] == 2'h2 && cmpa_sh inside {8'h00, 8'hFF}
    && (ctrl_sh[2:0] == 3'h1 || (ctrl_sh[2:0] == 3'h3 && cmpa_sh == 8'hFF))
    |-> compare_out[0] == (cmpa_sh == 8'hFF))
    else $error("extreme compare value not held constant");
  toggle_max_a: assert property (
    age == SETTLE && ctrl_sh[7:6] == 2'h1 && cmpa_sh == 8'h00
    && ctrl_sh[2:0] inside {3'h2, 3'h7}
    |=> compare_out[0] != $past(compare_out[0]))
    else $error("output a did not toggle every cycle");
  fast_pulse_a: assert property (
    age == SETTLE && ctrl_sh == 8'h83 && cmpa_sh == 8'h03
    && $rose(compare_out[0]) |-> compare_out[0][*4] ##1 !compare_out[0])
    else $error("fast pulse width wrong");
  dual_pulse_a: assert property (
    age == SETTLE && ctrl_sh == 8'h81 && cmpa_sh == 8'h03
    && $rose(compare_out[0]) |-> compare_out[0][*6] ##1 !compare_out[0])
    else $error("dual slope pulse width wrong");
endmodule : twm_timer_monitor

bind twm_timer twm_timer_monitor twm_timer_monitor_i (
  .clk(clk),
  .rst_n(rst_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_address(avs_address),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .compare_out(compare_out),
  .pin_out(pin_out),
  .pin_oe_n(pin_oe_n)
);

// ===== testbench/twm_timer_tb_top.sv
`timescale 1ns/1ps
`include "twm_defs.svh"
module twm_timer_tb_top;
  import twm_pkg::*;
  logic         clk = 1'b0;      // 200 MHz
  logic         rst_n;           // async reset
  twm_bus_req_t req;             // bus request
  logic [31:0]  avs_readdata;    // read data
  logic         avs_waitrequest; // slave wait
  logic [1:0]   compare_out;     // compare states
  logic [1:0]   pin_out;         // pad level driven
  logic [1:0]   pin_oe_n;        // pad enable, low drives
  logic [1:0]   pin_level;       // board level
  logic [31:0]  rdat;            // last read word
  int           num_errors;
  int           compares;

  twm_timer twm_timer_i (.clk(clk), .rst_n(rst_n), .avs_read(req.read),
    .avs_write(req.write), .avs_address(req.address),
    .avs_writedata(req.writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .compare_out(compare_out),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  twm_pin_load twm_pin_load_i (.pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_level(pin_level));

  always #2.5 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string msg);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: %s %0h not %0h", $time, msg, seen, exp);
    end
  endtask : check

  // one transfer; request held until wait request is seen low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    req <= '{read: !wr, write: wr, address: a, writedata: d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    // one wait cycle, then ready at the second edge
    check(n, 2, "bus answer");
    req.read  <= 1'b0;
    req.write <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0000_00, d});
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [31:0] m,
                    input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rdat & m, exp, "read data");
  endtask : rd

  // high cycles of output a and pad a over a whole number of periods
  task automatic wave(input logic [7:0] ctl, input logic [7:0] cmp,
                      input int win, input int exp);
    int hi;
    int lv;
    hi = 0;
    lv = 0;
    wr(`TWM_OFS_CTRL, ctl);
    wr(`TWM_OFS_CMP_A, cmp);
    // dual slope may need a full period to load, half more to settle
    repeat (1100) @(posedge clk);
    repeat (win)
    begin
      @(posedge clk);
      hi += (compare_out[0] === 1'b1);
      lv += (pin_level[0] === 1'b1);
    end
    check(hi, exp, "output high cycles");
    check(lv, exp, "pad high cycles");
  endtask : wave

  task automatic test_reset();
    check(compare_out, 2'b00, "reset output");
    check(pin_oe_n, 2'b11, "reset enable");
    check(avs_waitrequest, 1'b1, "reset wait");
    wr(5'h1C, 8'hFF);
    rd(5'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    rd(`TWM_OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    // divider register reads back, then back to a tick per clock
    wr(`TWM_OFS_DIV, 8'h03);
    rd(`TWM_OFS_DIV, 32'hFFFF_FFFF, 32'h0000_0003);
    wr(`TWM_OFS_DIV, 8'h00);
    $display("reset test done");
  endtask : test_reset

  task automatic test_pins();
    wr(`TWM_OFS_PINS, 8'h04);
    repeat (3) @(posedge clk);
    check(pin_level, 2'b00, "released pads");
    wr(`TWM_OFS_PINS, 8'h07);
    repeat (3) @(posedge clk);
    check(pin_oe_n, 2'b00, "driven pads");
    check(pin_level, 2'b01, "port levels");
    wr(`TWM_OFS_PINS, 8'h01);
    $display("pin test done");
  endtask : test_pins

  task automatic test_waves();
    wave(8'h83, 8'h40, 256, 65);
    wave(8'hC3, 8'h40, 256, 191);
    wave(8'h83, 8'h03, 256, 4);
    wave(8'h83, 8'hFF, 256, 256);
    wave(8'h83, 8'h00, 256, 1);
    wave(8'h47, 8'h09, 200, 100);
    wave(8'h47, 8'h00, 256, 128);
    wave(8'h81, 8'h40, 510, 128);
    wave(8'hC1, 8'h40, 510, 382);
    wave(8'h81, 8'h03, 510, 6);
    wave(8'h81, 8'h00, 510, 0);
    wave(8'h81, 8'hFF, 510, 510);
    wave(8'h45, 8'h05, 200, 100);
    wave(8'h42, 8'h03, 256, 128);
    wave(8'h42, 8'h00, 256, 128);
    $display("waveform test done");
  endtask : test_waves

  task automatic test_flags();
    wr(`TWM_OFS_CTRL, 8'h02);
    wr(`TWM_OFS_CMP_A, 8'h05);
    wr(`TWM_OFS_COUNT, 8'h20);
    wr(`TWM_OFS_FLAGS, 8'h07);
    repeat (100) @(posedge clk);
    rd(`TWM_OFS_FLAGS, 32'h3, 32'h0);
    repeat (200) @(posedge clk);
    rd(`TWM_OFS_FLAGS, 32'h3, 32'h3);
    wr(`TWM_OFS_CTRL, 8'h03);
    wr(`TWM_OFS_FLAGS, 8'h07);
    repeat (600) @(posedge clk);
    rd(`TWM_OFS_FLAGS, 32'h1, 32'h1);
    wr(`TWM_OFS_CTRL, 8'h01);
    wr(`TWM_OFS_FLAGS, 8'h07);
    repeat (600) @(posedge clk);
    rd(`TWM_OFS_FLAGS, 32'h1, 32'h1);
    $display("flag test done");
  endtask : test_flags

  // outputs must hold while the actions cannot act
  task automatic quiet(input logic [7:0] ctl);
    logic [1:0] was;
    wr(`TWM_OFS_CTRL, ctl);
    repeat (4) @(posedge clk);
    was = compare_out;
    repeat (600) @(posedge clk);
    check(compare_out, was, "outputs held");
  endtask : quiet

  task automatic test_quiet();
    quiet(8'h13);
    quiet(8'h43);
    $display("quiet test done");
  endtask : test_quiet

  task automatic complete_run();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial
  begin
    rst_n = 1'b0;
    req = '0;
    num_errors = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    test_reset();
    test_pins();
    test_waves();
    test_flags();
    test_quiet();
    complete_run();
  end

  // watchdog well past the expected run length
  initial
  begin
    repeat (60000) @(posedge clk);
    num_errors++;
    $display("ERROR at %0t: run did not finish", $time);
    complete_run();
  end
endmodule : twm_timer_tb_top
